// >>> ppe_parallel_port.sv
// parallel port block: port one edge events, external interrupts, general outputs, tri-level inputs
// Functional notes
// - port one pin edges raise events per select
// - per-pin mask blocks port one events
// - three event source registers, own interrupt lines
// - groups 1:0, 3:2, 7:4; read clears
// - ext pin change sets interrupt latch
// - ext interrupts gated by mask register into irq_o; irq_lines_o ungated
// - status read gives level, clears latch
// - ext pin c may follow antenna timing
// - seven outputs driven from control registers
// - output appears only when pin selected
// - tri-level a only when ctrl b bit7 low
// - tri-levels decoded to two-bit status codes
// - weak mid bias during tri-level reads
// - tri-level b sampled at reset, mode
`timescale 1ns/1ps
module ppe_parallel_port
  import ppe_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // pins
  input  wire logic [P1_W-1:0]   port_one_pin_i,
  input  wire logic [EXT_N-1:0]  ext_irq_pin_i,
  input  wire logic [TRI_N-1:0]  tri_hi_i,
  input  wire logic [TRI_N-1:0]  tri_lo_i,
  output logic      [TRI_N-1:0]  tri_bias_o,
  output logic      [GPO_N-1:0]  gen_output_o,
  output logic      [GPO_N-1:0]  gen_output_oe_o,
  // formatter timing, same clock
  input  wire logic              ant_switch_i,
  // interrupt controller side
  output logic      [IRQ_N-1:0]  irq_lines_o,
  output logic                   irq_o,
  output logic      [1:0]        op_mode_o,
  output logic                   op_mode_valid_o
);

  function automatic logic [1:0] tri_decode(input logic hi, input logic lo);
    if (lo)
      return TRI_LOW;
    else if (hi)
      return TRI_HIGH;
    else
      return TRI_MID;
  endfunction

  // synchronisers: stage one is read only by stage two
  // no reset, so the chain and the edge history track the pins during reset and no false edge follows it
  logic [P1_W-1:0]  p1_s1_ff, p1_s2_ff, p1_prev_ff;
  logic [EXT_N-1:0] ext_s1_ff, ext_s2_ff, ext_prev_ff;
  logic [TRI_N-1:0] hi_s1_ff, hi_s2_ff, lo_s1_ff, lo_s2_ff;

  always_ff @(posedge clk_i) begin
    p1_s1_ff  <= port_one_pin_i;
    p1_s2_ff  <= p1_s1_ff;
    ext_s1_ff <= ext_irq_pin_i;
    ext_s2_ff <= ext_s1_ff;
    hi_s1_ff  <= tri_hi_i;
    hi_s2_ff  <= hi_s1_ff;
    lo_s1_ff  <= tri_lo_i;
    lo_s2_ff  <= lo_s1_ff;
  end

  // software registers
  logic [REG_W-1:0] edge_sel_ff, evt_mask_ff, gpo_a_ff, gpo_b_ff, pin_mux_ff;
  logic [IRQ_N-1:0] irq_mask_ff;
  logic [P1_W-1:0]  src_ff;
  logic [EXT_N-1:0] ext_latch_ff;
  logic [1:0]       mode_ff;
  logic             mode_valid_ff;
  ppe_state_e       state_ff;
  logic [4:0]       settle_ff;

  // bus request decode
  logic        req, wr_acc, rd_acc;
  logic [7:0]  wdat;
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && (state_ff == PPE_IDLE);
  assign wr_acc = req && wb_we_i && wb_sel_i[0];
  assign wdat   = wb_dat_i[7:0];
  // the tri-level status read waits for the bias to settle first
  assign rd_acc = (req && !wb_we_i && wb_adr_i != ADR_XSTAT_A) ||
                  (state_ff == PPE_SETTLE && settle_ff == SETTLE_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel_ff <= RST_REG;
      evt_mask_ff <= RST_REG;
      gpo_a_ff    <= RST_REG;
      gpo_b_ff    <= RST_REG;
      pin_mux_ff  <= RST_REG;
      irq_mask_ff <= RST_MASK;
    end else if (wr_acc) begin
      case (wb_adr_i)
        ADR_EDGE_SEL: edge_sel_ff <= wdat;
        ADR_EVT_MASK: evt_mask_ff <= wdat;
        ADR_GPO_A:    gpo_a_ff    <= wdat;
        ADR_GPO_B:    gpo_b_ff    <= wdat;
        ADR_PIN_MUX:  pin_mux_ff  <= wdat;
        ADR_IRQ_MASK: irq_mask_ff <= wdat[IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  // port one events: 1 in select means rising edge
  logic [P1_W-1:0] p1_event, src_clr;
  always_ff @(posedge clk_i) begin
    p1_prev_ff <= p1_s2_ff;
  end
  assign p1_event = ((p1_s2_ff & ~p1_prev_ff & edge_sel_ff) |
                     (~p1_s2_ff & p1_prev_ff & ~edge_sel_ff)) & ~evt_mask_ff;

  logic rd_src_a, rd_src_b, rd_src_c, w1c;
  assign rd_src_a = rd_acc && wb_adr_i == ADR_SRC_A;
  assign rd_src_b = rd_acc && wb_adr_i == ADR_SRC_B;
  assign rd_src_c = rd_acc && wb_adr_i == ADR_SRC_C;
  assign w1c      = wr_acc && wb_adr_i == ADR_IRQ_STAT;

  genvar gi;
  generate
    for (gi = 0; gi < P1_W; gi++) begin : g_src
      if (gi <= SRC_A_HI) begin : g_a
        assign src_clr[gi] = rd_src_a || (w1c && wdat[IRQ_SRC]);
      end else if (gi <= SRC_B_HI) begin : g_b
        assign src_clr[gi] = rd_src_b || (w1c && wdat[IRQ_SRC + 1]);
      end else begin : g_c
        assign src_clr[gi] = rd_src_c || (w1c && wdat[IRQ_SRC + 2]);
      end
    end
  endgenerate

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i)
      src_ff <= '0;
    else
      src_ff <= (src_ff & ~src_clr) | p1_event;
  end

  // external interrupts; pin c may track the formatter's antenna timing instead
  logic [EXT_N-1:0] ext_cur, ext_change, ext_clr;
  assign ext_cur    = {pin_mux_ff[MUX_ANT_SEL] ? ant_switch_i : ext_s2_ff[2], ext_s2_ff[1:0]};
  assign ext_change = ext_cur ^ ext_prev_ff;
  assign ext_clr[0] = (rd_acc && wb_adr_i == ADR_XSTAT_A) || (w1c && wdat[IRQ_EXT]);
  assign ext_clr[1] = (rd_acc && wb_adr_i == ADR_XSTAT_B) || (w1c && wdat[IRQ_EXT + 1]);
  assign ext_clr[2] = (rd_acc && wb_adr_i == ADR_XSTAT_C) || (w1c && wdat[IRQ_EXT + 2]);

  always_ff @(posedge clk_i) begin
    ext_prev_ff <= ext_cur;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ext_latch_ff <= '0;
    else
      ext_latch_ff <= (ext_latch_ff & ~ext_clr) | ext_change;
  end

  // interrupt lines and summary output
  logic [IRQ_N-1:0] irq_stat;
  assign irq_stat = {|src_ff[SRC_C_HI:SRC_C_LO], |src_ff[SRC_B_HI:SRC_B_LO],
                     |src_ff[SRC_A_HI:SRC_A_LO], ext_latch_ff};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_lines_o <= RST_IRQ;
      irq_o       <= 1'b0;
    end else begin
      irq_lines_o <= irq_stat;
      irq_o       <= |(irq_stat & ~irq_mask_ff);
    end
  end

  // general outputs: out2..out7 from ctrl a, gen_output_ten from ctrl b
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_output_o    <= '0;
      gen_output_oe_o <= '0;
    end else begin
      gen_output_o    <= {gpo_b_ff[GPO_B_GEN_OUTPUT_TEN], gpo_a_ff[GPO_N-2:0]};
      gen_output_oe_o <= {gpo_b_ff[GPO_B_TRI_OFF], pin_mux_ff[GPO_N-2:0]};
    end
  end

  // tri-level sequencer: boot samples b as the mode strap, reads of status a sample b, and a too while ctrl b bit7 is low
  logic tri_a_on;
  assign tri_a_on = !gpo_b_ff[GPO_B_TRI_OFF];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff      <= PPE_BOOT;
      settle_ff     <= '0;
      mode_ff       <= TRI_NONE;
      mode_valid_ff <= 1'b0;
      tri_bias_o    <= '0;
    end else begin
      case (state_ff)
        PPE_BOOT: begin
          tri_bias_o <= 2'b10;
          settle_ff  <= settle_ff + 5'h01;
          if (settle_ff == SETTLE_LAST) begin
            mode_ff       <= tri_decode(hi_s2_ff[1], lo_s2_ff[1]);
            mode_valid_ff <= 1'b1;
            settle_ff     <= '0;
            tri_bias_o    <= '0;
            state_ff      <= PPE_IDLE;
          end
        end
        PPE_IDLE: begin
          if (req && !wb_we_i && wb_adr_i == ADR_XSTAT_A) begin
            tri_bias_o <= {1'b1, tri_a_on};
            state_ff   <= PPE_SETTLE;
          end
        end
        PPE_SETTLE: begin
          settle_ff <= settle_ff + 5'h01;
          if (settle_ff == SETTLE_LAST) begin
            settle_ff  <= '0;
            tri_bias_o <= '0;
            state_ff   <= PPE_IDLE;
          end
        end
        default: state_ff <= PPE_IDLE;
      endcase
    end
  end

  assign op_mode_o       = mode_ff;
  assign op_mode_valid_o = mode_valid_ff;

  // read mux; unmapped addresses read zero and ignore writes
  logic [7:0] rdat;
  logic [1:0] code_a, code_b;
  assign code_a = tri_a_on ? tri_decode(hi_s2_ff[0], lo_s2_ff[0]) : TRI_NONE;
  assign code_b = tri_decode(hi_s2_ff[1], lo_s2_ff[1]);
  always_comb begin
    rdat = 8'h00;
    case (wb_adr_i)
      ADR_EDGE_SEL: rdat = edge_sel_ff;
      ADR_EVT_MASK: rdat = evt_mask_ff;
      ADR_SRC_A:    rdat = {6'h00, src_ff[SRC_A_HI:SRC_A_LO]};
      ADR_SRC_B:    rdat = {6'h00, src_ff[SRC_B_HI:SRC_B_LO]};
      ADR_SRC_C:    rdat = {4'h0, src_ff[SRC_C_HI:SRC_C_LO]};
      ADR_XSTAT_A:  rdat = {2'h0, code_b, code_a, 1'b0, ext_cur[0]};
      ADR_XSTAT_B:  rdat = {7'h00, ext_cur[1]};
      ADR_XSTAT_C:  rdat = {7'h00, ext_cur[2]};
      ADR_GPO_A:    rdat = gpo_a_ff;
      ADR_GPO_B:    rdat = gpo_b_ff;
      ADR_PIN_MUX:  rdat = pin_mux_ff;
      ADR_IRQ_STAT: rdat = {2'h0, irq_stat};
      ADR_IRQ_MASK: rdat = {2'h0, irq_mask_ff};
      ADR_OP_MODE:  rdat = {mode_valid_ff, 5'h00, mode_ff};
      default:      rdat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= rd_acc || (req && wb_we_i);
      if (rd_acc)
        wb_dat_o <= {24'h000000, rdat};
    end
  end

  // checks
  p1_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p1_event[0] |=> src_ff[0]) else $error("port one event not recorded");
  mask_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt_mask_ff[5] && !src_ff[5] && !wr_acc) |=> !src_ff[5]) else $error("masked pin set source");
  src_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_src_a && p1_event[1:0] == 2'b00) |=> src_ff[1:0] == 2'b00) else $error("source a not cleared");
  ext_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_change[1] |=> ##1 irq_lines_o[1]) else $error("ext change lost");
  ext_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_clr[2] && !ext_change[2]) |=> !ext_latch_ff[2]) else $error("ext latch not cleared");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(|(irq_stat & ~irq_mask_ff))) else $error("irq without unmasked cause");
  out_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_output_oe_o[6] == $past(gpo_b_ff[GPO_B_TRI_OFF])) else $error("out ten enable wrong");
  tri_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(!tri_a_on) && $past(state_ff) == PPE_IDLE |-> !tri_bias_o[0]) else $error("tri a biased");
  mode_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    op_mode_valid_o |=> $stable(op_mode_o)) else $error("strap mode changed");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  settle_bias_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == PPE_SETTLE |-> tri_bias_o[1]) else $error("bias off during tri read");
endmodule

// >>> ppe_pkg.sv
// package: register map, field layout and timing constants of the parallel port block
package ppe_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [7:0] ADR_EDGE_SEL  = 8'h00;
  localparam logic [7:0] ADR_EVT_MASK  = 8'h04;
  localparam logic [7:0] ADR_SRC_A     = 8'h08;
  localparam logic [7:0] ADR_SRC_B     = 8'h0C;
  localparam logic [7:0] ADR_SRC_C     = 8'h10;
  localparam logic [7:0] ADR_XSTAT_A   = 8'h14;
  localparam logic [7:0] ADR_XSTAT_B   = 8'h18;
  localparam logic [7:0] ADR_XSTAT_C   = 8'h1C;
  localparam logic [7:0] ADR_GPO_A     = 8'h20;
  localparam logic [7:0] ADR_GPO_B     = 8'h24;
  localparam logic [7:0] ADR_PIN_MUX   = 8'h28;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h2C;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h30;
  localparam logic [7:0] ADR_OP_MODE   = 8'h34;

  // widths
  localparam int P1_W   = 8;
  localparam int EXT_N  = 3;
  localparam int GPO_N  = 7;
  localparam int TRI_N  = 2;
  localparam int IRQ_N  = 6;
  localparam int REG_W  = 8;

  // reset values
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [5:0] RST_IRQ  = 6'h00;
  localparam logic [5:0] RST_MASK = 6'h3F;

  // event source groups of port one pins
  localparam int SRC_A_LO = 0;
  localparam int SRC_A_HI = 1;
  localparam int SRC_B_LO = 2;
  localparam int SRC_B_HI = 3;
  localparam int SRC_C_LO = 4;
  localparam int SRC_C_HI = 7;

  // field positions
  localparam int GPO_B_GEN_OUTPUT_TEN   = 0;  // level of output ten in ctrl b
  localparam int GPO_B_TRI_OFF = 7;  // 1: shared pin is output ten, tri-level a off
  localparam int MUX_ANT_SEL   = 7;  // 1: ext pin c follows antenna switch timing
  localparam int XST_TRI_A     = 2;
  localparam int XST_TRI_B     = 4;
  localparam int IRQ_EXT       = 0;  // bits 2:0 ext latches, 5:3 port one groups
  localparam int IRQ_SRC       = 3;

  // tri-level codes
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_MID  = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  localparam logic [1:0] TRI_NONE = 2'h3;

  // settling time of the mid-supply bias before a tri-level sample
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int TRI_SETTLE_NS   = 40;
  localparam int TRI_SETTLE_CYC  = (TRI_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] SETTLE_LAST = 5'(TRI_SETTLE_CYC - 1);

  typedef enum logic [1:0] {
    PPE_BOOT   = 2'b00,
    PPE_IDLE   = 2'b01,
    PPE_SETTLE = 2'b10
  } ppe_state_e;
endpackage

// >>> ppe_pin_model.sv
// board side model: port one drivers, interrupt sources and tri-level straps
`timescale 1ns/1ps
module ppe_pin_model
  import ppe_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // levels commanded by the bench
  input  wire logic [P1_W-1:0]   p1_lvl_i,
  input  wire logic [EXT_N-1:0]  ext_lvl_i,
  input  wire logic [3:0]        strap_i,
  // pins towards the block
  input  wire logic [TRI_N-1:0]  tri_bias_i,
  output logic      [P1_W-1:0]   p1_pin_o,
  output logic      [EXT_N-1:0]  ext_pin_o,
  output logic      [TRI_N-1:0]  tri_hi_o,
  output logic      [TRI_N-1:0]  tri_lo_o
);
  logic toggle_ff = 1'b0;

  always_ff @(posedge clk_i) begin
    toggle_ff <= ~toggle_ff;
  end

  assign p1_pin_o  = p1_lvl_i;
  assign ext_pin_o = ext_lvl_i;

  // strap code per pin: 0 tied low, 1 open, 2 tied high
  always_comb begin
    for (int i = 0; i < TRI_N; i++) begin
      tri_lo_o[i] = (strap_i[2*i+:2] == 2'h0);
      tri_hi_o[i] = (strap_i[2*i+:2] == 2'h2);
      // an open pin settles at mid-supply only under the weak bias, else it wanders
      if (strap_i[2*i+:2] == 2'h1 && tri_bias_i[i] !== 1'b1) begin
        tri_lo_o[i] = toggle_ff;
        tri_hi_o[i] = ~toggle_ff;
      end
    end
  end
endmodule

// >>> test_parallel_port_event_io.sv
// self-checking bench of the parallel port block
`timescale 1ns/1ps
module test_parallel_port_event_io
  import ppe_pkg::*;
;
  logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, op_mode_valid_o, ant_switch_i;
  logic [7:0]        wb_adr_i, p1_lvl, p1_pin;
  logic [3:0]        wb_sel_i, strap;
  logic [31:0]       wb_dat_i, wb_dat_o, d;
  logic [EXT_N-1:0]  ext_lvl, ext_pin;
  logic [TRI_N-1:0]  tri_hi, tri_lo, tri_bias_o;
  logic [GPO_N-1:0]  gen_output_o, gen_output_oe_o;
  logic [IRQ_N-1:0]  irq_lines_o;
  logic [1:0]        op_mode_o;
  logic              bias_seen;
  int                n_errors, compares;

  ppe_parallel_port u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_one_pin_i(p1_pin), .ext_irq_pin_i(ext_pin), .tri_hi_i(tri_hi),
    .tri_lo_i(tri_lo), .tri_bias_o(tri_bias_o), .gen_output_o(gen_output_o),
    .gen_output_oe_o(gen_output_oe_o), .ant_switch_i(ant_switch_i), .irq_lines_o(irq_lines_o),
    .irq_o(irq_o), .op_mode_o(op_mode_o), .op_mode_valid_o(op_mode_valid_o));

  ppe_pin_model u_pins (
    .clk_i(clk_i), .p1_lvl_i(p1_lvl), .ext_lvl_i(ext_lvl), .strap_i(strap), .tri_bias_i(tri_bias_o),
    .p1_pin_o(p1_pin), .ext_pin_o(ext_pin), .tri_hi_o(tri_hi), .tri_lo_o(tri_lo));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic finish_test;
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle; the request stands until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (tri_bias_o[0] === 1'b1) bias_seen = 1'b1;
    end while (wb_ack_o !== 1'b1 && n < 60);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t no bus answer", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] x;
    wb(1'b1, adr, dat, x);
  endtask

  task automatic rd(input logic [7:0] adr);
    wb(1'b0, adr, 8'h00, d);
  endtask

  task automatic t_boot;
    int n;
    for (n = 0; n < 40 && op_mode_valid_o !== 1'b1; n++) @(posedge clk_i);
    if (op_mode_valid_o !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t boot never finished", $time);
      finish_test();
    end
    chk(op_mode_o, TRI_HIGH);
    rd(ADR_OP_MODE);
    chk(d, {24'h0, 1'b1, 5'h0, TRI_HIGH});
    rd(ADR_IRQ_MASK);
    chk(d, RST_MASK);
    wr(8'h3C, 8'hFF);
    rd(8'h3C);
    chk(d, 32'h0);
    chk(gen_output_oe_o, 7'h00);
  endtask

  task automatic t_p1_edges;
    wr(ADR_EDGE_SEL, 8'h0F);
    wr(ADR_EVT_MASK, 8'h00);
    p1_lvl <= 8'h0F;
    tick(6);
    chk(irq_lines_o[5:3], 3'b111);
    rd(ADR_SRC_A);
    chk(d, 32'h03);
    rd(ADR_SRC_B);
    chk(d, 32'h03);
    rd(ADR_SRC_C);
    chk(d, 32'h0F);
    tick(2);
    chk(irq_lines_o[5:3], 3'b000);
    rd(ADR_SRC_C);
    chk(d, 32'h00);
    // opposite transitions must record nothing
    p1_lvl <= 8'hF0;
    tick(6);
    chk(irq_lines_o[5:3], 3'b000);
  endtask

  task automatic t_p1_mask;
    wr(ADR_EVT_MASK, 8'hFE);
    wr(ADR_IRQ_MASK, 8'h37);
    p1_lvl <= 8'hF3;
    tick(6);
    chk(irq_o, 1'b1);
    rd(ADR_SRC_A);
    chk(d, 32'h01);
    tick(3);
    chk(irq_o, 1'b0);
    wr(ADR_IRQ_MASK, 8'h3F);
  endtask

  task automatic t_ext;
    logic lvl;
    for (int i = 0; i < EXT_N; i++) begin
      lvl = ~ext_lvl[i];
      ext_lvl[i] <= lvl;
      tick(6);
      chk(irq_lines_o[i], 1'b1);
      chk(irq_o, 1'b0);
      wr(ADR_IRQ_MASK, 8'h3F & ~(8'h01 << i));
      tick(2);
      chk(irq_o, 1'b1);
      rd(ADR_XSTAT_A + 8'(4 * i));
      chk(d[0], lvl);
      tick(2);
      chk(irq_lines_o[i], 1'b0);
      wr(ADR_IRQ_MASK, 8'h3F);
    end
    ext_lvl[1] <= ~ext_lvl[1];
    tick(6);
    wr(ADR_IRQ_STAT, 8'h02);
    tick(2);
    chk(irq_lines_o[1], 1'b0);
  endtask

  task automatic t_tri;
    logic [1:0] exp;
    for (int s = 0; s < 3; s++) begin
      strap[1:0] <= 2'(s);
      exp = (s == 0) ? TRI_LOW : (s == 1) ? TRI_MID : TRI_HIGH;
      bias_seen = 1'b0;
      rd(ADR_XSTAT_A);
      chk(d[3:2], exp);
      chk(d[5:4], TRI_HIGH);
      chk(bias_seen, 1'b1);
    end
    wr(ADR_GPO_B, 8'h80);
    bias_seen = 1'b0;
    rd(ADR_XSTAT_A);
    chk(d[3:2], TRI_NONE);
    chk(bias_seen, 1'b0);
  endtask

  task automatic t_gpo;
    wr(ADR_GPO_A, 8'h2A);
    wr(ADR_GPO_B, 8'h81);
    wr(ADR_PIN_MUX, 8'h3F);
    tick(2);
    chk(gen_output_o, 7'h6A);
    chk(gen_output_oe_o, 7'h7F);
    wr(ADR_PIN_MUX, 8'h05);
    wr(ADR_GPO_B, 8'h01);
    tick(2);
    chk(gen_output_oe_o, 7'h05);
  endtask

  task automatic t_ant;
    wr(ADR_PIN_MUX, 8'h80);
    tick(4);
    rd(ADR_XSTAT_C);
    ant_switch_i <= 1'b1;
    tick(6);
    chk(irq_lines_o[2], 1'b1);
    rd(ADR_XSTAT_C);
    chk(d[0], 1'b1);
    tick(2);
    chk(irq_lines_o[2], 1'b0);
  endtask

  initial begin
    rst_i        = 1'b1;
    wb_cyc_i     = 1'b0;
    wb_stb_i     = 1'b0;
    wb_we_i      = 1'b0;
    wb_adr_i     = 8'h00;
    wb_sel_i     = 4'h1;
    wb_dat_i     = 32'h0;
    p1_lvl       = 8'hF0;
    ext_lvl      = 3'h0;
    strap        = 4'h9;
    ant_switch_i = 1'b0;
    n_errors     = 0;
    compares     = 0;
    tick(4);
    rst_i <= 1'b0;
    t_boot();
    t_p1_edges();
    t_p1_mask();
    t_ext();
    t_tri();
    t_gpo();
    t_ant();
    finish_test();
  end
endmodule
